// ---- hw/dpd_pkg.sv ----
// Constants and types of the downstream pseudowire datapath
package dpd_pkg;
  // ----------------------------------------
  // Clocking and timebase
  // ----------------------------------------
  localparam int CLK_KHZ = 50000;
  localparam int MCLK_KHZ = 10240;
  localparam int TS_GCD = 40;
  localparam logic [11:0] TS_INC = 12'(MCLK_KHZ / TS_GCD);
  localparam logic [11:0] TS_MOD = 12'(CLK_KHZ / TS_GCD);
  localparam logic [3:0] BYTE_DIV = 4'ha;
  // ----------------------------------------
  // Framing
  // ----------------------------------------
  localparam int NFLOW = 4;
  localparam int FW = 2;
  localparam int PKT_LEN = 188;
  localparam logic [7:0] LAST_IDX = 8'hbb;
  localparam logic [7:0] FRAME_LAST = 8'hb6;
  localparam logic [7:0] PTR_IDX = 8'h04;
  localparam logic [7:0] SYNC_OFS = 8'h05;
  localparam logic [7:0] SYNC_BYTES = 8'h1e;
  localparam logic [7:0] TS_FIRST = 8'h1f;
  localparam logic [7:0] TS_LAST = 8'h22;
  localparam logic [7:0] SA_IDX = 8'h11;
  localparam logic [7:0] TS_SYNC = 8'h47;
  localparam logic [7:0] STUFF = 8'hff;
  localparam logic [12:0] NULL_PID = 13'h1fff;
  localparam logic [12:0] DATA_PID = 13'h0100;
  localparam logic [5:0] PHB_EF = 6'h2e;
  localparam logic [5:0] PHB_BE = 6'h00;
  // ----------------------------------------
  // Timing message fields
  // ----------------------------------------
  localparam logic [7:0] FC_TIMING = 8'hc0;
  localparam logic [15:0] MAC_LEN = 16'h0018;
  localparam logic [15:0] MSG_LEN = 16'h000a;
  localparam logic [7:0] LLC_SAP = 8'h00;
  localparam logic [7:0] LLC_UI = 8'h03;
  localparam logic [7:0] MSG_VER = 8'h01;
  localparam logic [7:0] MSG_TYPE = 8'h01;
  // Arbitrary value, not a real group address
  localparam logic [47:0] SYNC_DA = 48'h0100_0000_00aa;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_IVL = 3'h1;
  localparam logic [2:0] REG_SA_LO = 3'h2;
  localparam logic [2:0] REG_SA_HI = 3'h3;
  localparam logic [2:0] REG_PHB = 3'h4;
  localparam logic [2:0] REG_STAT = 3'h5;
  localparam logic [2:0] REG_TS = 3'h6;
  localparam logic [2:0] REG_CAP = 3'h7;
  localparam int CTRL_PSP = 0;
  localparam int CTRL_OFDM = 1;
  localparam int CTRL_DMAP = 2;
  localparam logic [2:0] CTRL_RST = 3'h1;
  localparam logic [15:0] IVL_RST = 16'h0010;
  localparam logic [23:0] PHB_RST = 24'h0;
  localparam logic [31:0] CAP_VAL = 32'h0000_0214;
  typedef enum logic [1:0] {PK_NULL, PK_DATA, PK_SYNC, PK_PASS} dpd_kind_t;
endpackage : dpd_pkg

// ---- hw/dpd_top.sv ----
// Downstream pseudowire datapath: reassembly, scheduling, framing
`timescale 1ns/1ps
module dpd_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [dpd_pkg::FW-1:0] in_flow,
  input wire logic [15:0] in_seq,
  output logic [dpd_pkg::NFLOW-1:0] flow_rdy,
  output logic ts_valid,
  output logic ts_sop,
  output logic [7:0] ts_data
);
  import dpd_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [2:0] ctrl_r;
  logic [15:0] ivl_r;
  logic [47:0] sa_r;
  logic [23:0] phb_r;
  logic [15:0] drop_cnt_r;
  logic [31:0] ts_cnt_r;
  logic [NFLOW-1:0] full_r;
  dpd_kind_t kind_r;
  logic [31:0] rd_mux;
  wire psp_mode;
  wire dmap = ctrl_r[CTRL_DMAP];
  assign psp_mode = ctrl_r[CTRL_PSP] | ctrl_r[CTRL_OFDM];
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= CTRL_RST;
      ivl_r <= IVL_RST;
      sa_r <= 48'h0;
      phb_r <= PHB_RST;
    end else if (reg_we) begin
      if (reg_addr == REG_CTRL) ctrl_r <= reg_wdata[2:0];
      if (reg_addr == REG_IVL) ivl_r <= reg_wdata[15:0];
      if (reg_addr == REG_SA_LO) sa_r[31:0] <= reg_wdata;
      if (reg_addr == REG_SA_HI) sa_r[47:32] <= reg_wdata[15:0];
      if (reg_addr == REG_PHB) phb_r <= reg_wdata[23:0];
    end
  end
  assign rd_mux = (reg_addr == REG_CTRL) ? {29'h0, ctrl_r} :
                  (reg_addr == REG_IVL) ? {16'h0, ivl_r} :
                  (reg_addr == REG_SA_LO) ? sa_r[31:0] :
                  (reg_addr == REG_SA_HI) ? {16'h0, sa_r[47:32]} :
                  (reg_addr == REG_PHB) ? {8'h0, phb_r} :
                  (reg_addr == REG_STAT) ? {drop_cnt_r, 8'h0, 2'(kind_r), 2'b0, full_r} :
                  (reg_addr == REG_TS) ? ts_cnt_r : CAP_VAL;
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) reg_rdata <= 32'h0;
    else reg_rdata <= reg_re ? rd_mux : 32'h0;
  end
  // ----------------------------------------
  // Master timebase and byte pacing
  // ----------------------------------------
  logic [11:0] acc_r;
  logic [3:0] div_r;
  logic byte_en_r;
  wire [11:0] acc_sum = acc_r + TS_INC;
  wire tick = acc_sum >= TS_MOD;
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      acc_r <= 12'h0;
      ts_cnt_r <= 32'h0;
      div_r <= 4'h0;
      byte_en_r <= 1'b0;
    end else begin
      acc_r <= tick ? acc_sum - TS_MOD : acc_sum;
      if (tick) ts_cnt_r <= ts_cnt_r + 32'h1;
      div_r <= (div_r == BYTE_DIV - 4'h1) ? 4'h0 : div_r + 4'h1;
      byte_en_r <= (div_r == BYTE_DIV - 4'h1);
    end
  end
  // ----------------------------------------
  // Input reassembly
  // ----------------------------------------
  logic [7:0] buf_r [NFLOW][PKT_LEN];
  logic [7:0] wptr_r [NFLOW];
  logic [NFLOW-1:0] full_nxt, avail;
  logic [FW-1:0] sel_r;
  logic [7:0] idx_r;
  logic [15:0] last_seq_r;
  logic have_seq_r, drop_r;
  // Flow id ignored outside packet mode
  wire [FW-1:0] wf = psp_mode ? in_flow : '0;
  wire [15:0] seq_diff = in_seq - last_seq_r;
  wire stale = !psp_mode && have_seq_r && (seq_diff == 16'h0 || seq_diff[15]);
  wire accept = in_valid && !full_r[wf] && (in_sop ? !stale : !drop_r);
  wire last_byte = in_eop || wptr_r[wf] == (psp_mode ? FRAME_LAST : LAST_IDX);
  wire slot = byte_en_r && idx_r == LAST_IDX;
  wire rel = slot && (kind_r == PK_DATA || kind_r == PK_PASS);
  always_comb begin
    avail = full_r;
    if (rel) avail[sel_r] = 1'b0;
    full_nxt = avail;
    if (accept && last_byte) full_nxt[wf] = 1'b1;
  end
  // Storage needs no reset; the full flags guard it
  always_ff @(posedge clk) begin
    if (accept) buf_r[wf][wptr_r[wf]] <= in_data;
  end
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int f = 0; f < NFLOW; f++) wptr_r[f] <= 8'h0;
      full_r <= '0;
      flow_rdy <= '0;
      drop_r <= 1'b0;
      have_seq_r <= 1'b0;
      last_seq_r <= 16'h0;
      drop_cnt_r <= 16'h0;
    end else begin
      full_r <= full_nxt;
      flow_rdy <= psp_mode ? ~full_nxt : {NFLOW{~full_nxt[0]}};
      if (rel) wptr_r[sel_r] <= 8'h0;
      if (accept) wptr_r[wf] <= wptr_r[wf] + 8'h1;
      if (in_valid && in_sop && !full_r[wf]) drop_r <= stale && !in_eop;
      else if (in_valid && in_eop) drop_r <= 1'b0;
      if (accept && in_sop && !psp_mode) begin
        have_seq_r <= 1'b1;
        last_seq_r <= in_seq;
      end
      if (in_valid && in_sop && stale && !full_r[wf]) drop_cnt_r <= drop_cnt_r + 16'h1;
    end
  end
  // ----------------------------------------
  // Packet scheduler
  // ----------------------------------------
  logic best_v, best_ef, ef_any;
  logic [FW-1:0] best_f;
  logic [2:0] best_k;
  always_comb begin
    logic [2:0] k;
    logic ef;
    k = 3'h0;
    ef = 1'b0;
    best_v = 1'b0;
    best_f = '0;
    best_k = 3'h0;
    best_ef = 1'b0;
    ef_any = 1'b0;
    for (int f = 0; f < NFLOW; f++) begin
      // Other hop values share best effort
      ef = phb_r[6*f +: 6] == PHB_EF;
      // Direct map ranks by flow number
      k = dmap ? 3'(f) : {ef, 2'b00};
      if (avail[f] && ef) ef_any = 1'b1;
      // Strict priority, lowest flow on ties
      if (avail[f] && (!best_v || k > best_k)) begin
        best_v = 1'b1;
        best_f = FW'(f);
        best_k = k;
        best_ef = ef;
      end
    end
  end
  logic [15:0] since_sync_r;
  logic [3:0] cc_r;
  logic fix_r;
  wire sync_due = psp_mode && since_sync_r >= ivl_r;
  wire [7:0] hdr1 = buf_r[0][1];
  wire fix_nxt = hdr1[6] && buf_r[0][PTR_IDX] == 8'h00 && buf_r[0][SYNC_OFS] == FC_TIMING;
  dpd_kind_t kind_nxt;
  // Null only when no frame waits
  assign kind_nxt = !psp_mode ? (avail[0] ? PK_PASS : PK_NULL) :
                    sync_due ? PK_SYNC : best_v ? PK_DATA : PK_NULL;
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      kind_r <= PK_NULL;
      sel_r <= '0;
      fix_r <= 1'b0;
      since_sync_r <= 16'h0;
      cc_r <= 4'h0;
    end else if (slot) begin
      kind_r <= kind_nxt;
      sel_r <= psp_mode ? best_f : '0;
      fix_r <= fix_nxt && kind_nxt == PK_PASS;
      if (kind_nxt == PK_SYNC) since_sync_r <= 16'h0;
      else if (since_sync_r != 16'hffff) since_sync_r <= since_sync_r + 16'h1;
      if (kind_r != PK_NULL) cc_r <= cc_r + 4'h1;
    end
  end
  // ----------------------------------------
  // Transmission convergence
  // ----------------------------------------
  logic [31:0] ts_lat_r;
  wire [12:0] pid = (kind_r == PK_NULL) ? NULL_PID : DATA_PID;
  wire pusi = kind_r == PK_DATA || kind_r == PK_SYNC;
  wire [7:0] ofs = idx_r - SYNC_OFS;
  wire [239:0] sync_vec = {FC_TIMING, 8'h00, MAC_LEN, 16'h0000, SYNC_DA, sa_r,
                           MSG_LEN, LLC_SAP, LLC_SAP, LLC_UI, MSG_VER, MSG_TYPE,
                           8'h00, ts_lat_r};
  wire [239:0] sync_sh = sync_vec >> {(SYNC_BYTES - 8'h1 - ofs), 3'b000};
  wire [31:0] ts_sh = ts_lat_r >> {(TS_LAST - idx_r), 3'b000};
  wire [7:0] pass_byte = buf_r[0][idx_r];
  wire in_ts = idx_r >= TS_FIRST && idx_r <= TS_LAST;
  wire [7:0] data_byte = (ofs < wptr_r[sel_r]) ? buf_r[sel_r][ofs] : STUFF;
  wire [7:0] sync_byte = (ofs < SYNC_BYTES) ? sync_sh[7:0] : STUFF;
  wire [7:0] hdr_byte = (idx_r == 8'h0) ? TS_SYNC :
                        (idx_r == 8'h1) ? {1'b0, pusi, 1'b0, pid[12:8]} :
                        (idx_r == 8'h2) ? pid[7:0] : {4'h1, cc_r};
  logic [7:0] out_byte;
  always_comb begin
    out_byte = STUFF;
    unique case (kind_r)
      PK_NULL: out_byte = (idx_r < PTR_IDX) ? hdr_byte : STUFF;
      PK_PASS: out_byte = (fix_r && in_ts) ? ts_sh[7:0] : pass_byte;
      // One frame per packet, stuff after
      PK_DATA: out_byte = (idx_r < PTR_IDX) ? hdr_byte :
                          (idx_r == PTR_IDX) ? 8'h00 : data_byte;
      // Pointer then message at sixth byte
      PK_SYNC: out_byte = (idx_r < PTR_IDX) ? hdr_byte :
                          (idx_r == PTR_IDX) ? 8'h00 : sync_byte;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      idx_r <= 8'h0;
      ts_lat_r <= 32'h0;
      ts_valid <= 1'b0;
      ts_sop <= 1'b0;
      ts_data <= 8'h0;
    end else begin
      ts_valid <= byte_en_r;
      ts_sop <= byte_en_r && idx_r == 8'h0;
      if (byte_en_r) begin
        ts_data <= out_byte;
        idx_r <= slot ? 8'h0 : idx_r + 8'h1;
        if (idx_r == SYNC_OFS) ts_lat_r <= ts_cnt_r;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_r);
  a_frame_queued: assert property (
    accept && last_byte && psp_mode |=> full_r[$past(wf)] && !flow_rdy[$past(wf)])
    else $error("completed frame not queued");
  a_null_pid: assert property (
    byte_en_r && idx_r == 8'h1 && kind_r == PK_NULL |=> ts_valid && ts_data == 8'h1f)
    else $error("null packet pid wrong");
  a_sync_start: assert property (
    byte_en_r && idx_r == SYNC_OFS && kind_r == PK_SYNC |=> ts_data == FC_TIMING)
    else $error("timing message not at sixth byte");
  a_sync_source: assert property (
    byte_en_r && idx_r == SA_IDX && kind_r == PK_SYNC |=> ts_data == sa_r[47:40])
    else $error("timing source address wrong");
  a_ef_first: assert property (
    slot && psp_mode && !dmap && ef_any |-> best_ef)
    else $error("expedited queue not served first");
  a_no_idle_null: assert property (
    slot && (psp_mode ? best_v : avail[0]) |=> kind_r != PK_NULL)
    else $error("null sent while data waits");
  a_ts_count: assert property (
    tick |=> ts_cnt_r == $past(ts_cnt_r) + 32'h1)
    else $error("timestamp did not advance");
  a_stale_drop: assert property (
    in_valid && in_sop && stale && !full_r[wf] |=>
      drop_cnt_r == $past(drop_cnt_r) + 16'h1 && drop_r == !$past(in_eop))
    else $error("stale packet not dropped");
  a_dmap_order: assert property (
    slot && psp_mode && dmap && best_v |-> (avail >> best_f) == 4'h1)
    else $error("direct map order wrong");
  a_sync_due: assert property (
    slot && sync_due |=> kind_r == PK_SYNC && since_sync_r == 16'h0)
    else $error("timing message not inserted");
  a_pass_clean: assert property (
    byte_en_r && kind_r == PK_PASS && !(fix_r && in_ts) |=> ts_data == $past(pass_byte))
    else $error("passthrough byte modified");
  c_null: cover property (slot && kind_nxt == PK_NULL);
  c_sync: cover property (slot && kind_nxt == PK_SYNC);
  c_data: cover property (slot && kind_nxt == PK_DATA && best_ef);
  c_fix: cover property (slot && fix_nxt && kind_nxt == PK_PASS);
endmodule : dpd_top

// ---- sim/dpd_tb_pkg.sv ----
// Byte patterns shared by the bench and the core model
package dpd_tb_pkg;
  function automatic logic [7:0] dpd_byte(input logic pass, input logic [1:0] fl,
      input logic [7:0] salt, input logic [7:0] k);
    if (pass) begin
      // Zero salt embeds a timing message
      if (salt == 8'h00 && k == 8'h01) return 8'h42;
      if (salt == 8'h00 && k == 8'h05) return 8'hc0;
      case (k)
        8'h00: return 8'h47;
        8'h01: return 8'h02;
        8'h02: return 8'h00;
        8'h03: return 8'h10;
        8'h04: return salt;
        default: return salt ^ (k * 8'h07);
      endcase
    end
    // First byte marks the flow, never a timing code
    if (k == 8'h00) return {6'h00, fl} + 8'h01;
    return salt + k;
  endfunction : dpd_byte
endpackage : dpd_tb_pkg

// ---- sim/dpd_core_model.sv ----
// Behavioural headend core feeding the datapath input stream
`timescale 1ns/1ps
module dpd_core_model
  import dpd_tb_pkg::*;
(
  input wire logic clk,
  input wire logic start,
  input wire logic pass,
  input wire logic slow,
  input wire logic [1:0] flow,
  input wire logic [7:0] len,
  input wire logic [7:0] salt,
  input wire logic [15:0] seq,
  input wire logic [3:0] flow_rdy,
  output logic busy,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_sop,
  output logic in_eop,
  output logic [1:0] in_flow,
  output logic [15:0] in_seq
);
  logic [7:0] k_r = 8'h00;
  logic [7:0] cur;
  int seed_r = 7;
  wire taken = in_valid && flow_rdy[in_flow];
  assign cur = dpd_byte(pass, in_flow, salt, k_r);
  // Idle bus shows the inverse, so a stale byte never looks valid
  assign in_data = in_valid ? cur : ~cur;
  assign in_sop = in_valid && (k_r == 8'h00);
  assign in_eop = in_valid && (k_r == len - 8'h01);
  initial begin
    busy = 1'b0;
    in_valid = 1'b0;
    in_flow = 2'h0;
    in_seq = 16'h0000;
  end
  // one kind per frame, flows 0 to 3
  always @(posedge clk) begin
    if (start && !busy) begin
      busy <= 1'b1;
      k_r <= 8'h00;
      in_flow <= flow;
      in_seq <= seq;
    end else if (taken && in_eop) begin
      busy <= 1'b0;
      in_valid <= 1'b0;
    end else if (taken) begin
      k_r <= k_r + 8'h01;
      in_valid <= !slow || $random(seed_r) % 2 == 0;
    end else if (busy) begin
      in_valid <= 1'b1;
    end
  end
endmodule : dpd_core_model

// ---- sim/testbench.sv ----
// Self-checking bench for the downstream pseudowire datapath
`timescale 1ns/1ps
module testbench;
  import dpd_pkg::*;
  import dpd_tb_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d, t0, sa_lo, sa_hi;
  logic in_valid, in_sop, in_eop, busy, ts_valid, ts_sop;
  logic [7:0] in_data, ts_data, l, s;
  logic [1:0] in_flow, f;
  logic [15:0] in_seq;
  logic [NFLOW-1:0] flow_rdy;
  logic start = 1'b0, pass = 1'b0, slow = 1'b0;
  logic [1:0] flow = 2'h0;
  logic [7:0] len = 8'h01, salt = 8'h00;
  logic [15:0] seq = 16'h0;
  logic [7:0] pkt [0:187];
  logic [215:0] sv;
  int num_errors = 0, comparisons = 0, seed = 45385;
  always #10 clk = ~clk;
  dpd_top uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop), .in_flow(in_flow), .in_seq(in_seq),
    .flow_rdy(flow_rdy), .ts_valid(ts_valid), .ts_sop(ts_sop), .ts_data(ts_data));
  dpd_core_model u_core (.clk(clk), .start(start), .pass(pass), .slow(slow), .flow(flow),
    .len(len), .salt(salt), .seq(seq), .flow_rdy(flow_rdy), .busy(busy), .in_valid(in_valid),
    .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop), .in_flow(in_flow), .in_seq(in_seq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask : rd
  task automatic sync_sop;
    int n;
    n = 0;
    do @(negedge clk); while (ts_sop !== 1'b1 && ++n < 4000);
    if (ts_sop !== 1'b1) num_errors++;
  endtask : sync_sop
  task automatic get_pkt;
    int n;
    sync_sop();
    pkt[0] = ts_data;
    for (int k = 1; k < PKT_LEN; k++) begin
      n = 0;
      do @(negedge clk); while (ts_valid !== 1'b1 && ++n < 20);
      if (ts_valid !== 1'b1) num_errors++;
      pkt[k] = ts_data;
    end
  endtask : get_pkt
  task automatic find(input logic [7:0] b1, input logic [7:0] b5, input logic use5);
    int n;
    n = 0;
    do begin
      get_pkt();
      n++;
    end while (!(pkt[1] === b1 && (!use5 || pkt[5] === b5)) && n < 6);
    if (!(pkt[1] === b1 && (!use5 || pkt[5] === b5))) num_errors++;
  endtask : find
  // Slow mode stalls the core between bytes
  task automatic send(input logic p, input logic [1:0] fl, input logic [7:0] ln,
      input logic [7:0] sl, input logic [15:0] q, input logic full);
    int n;
    @(posedge clk);
    pass <= p;
    flow <= fl;
    len <= ln;
    salt <= sl;
    seq <= q;
    slow <= $random(seed) % 2 == 0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do @(negedge clk); while (busy !== 1'b0 && ++n < 6000);
    if (busy !== 1'b0) num_errors++;
    if (full) chk("flow_rdy", flow_rdy[fl], 1'b0);
  endtask : send
  task automatic chk_frame(input logic [1:0] fl, input logic [7:0] ln, input logic [7:0] sl);
    find(8'h41, 8'(fl) + 8'h01, 1'b1);
    chk("data hdr", {pkt[0], pkt[1], pkt[2], pkt[4]}, {TS_SYNC, 8'h41, 8'h00, 8'h00});
    for (int k = 0; k < 183; k++)
      chk("frame", pkt[k+5], k < ln ? dpd_byte(1'b0, fl, sl, 8'(k)) : STUFF);
  endtask : chk_frame
  // Frames land in the same decision window; winner first, then loser, then idle
  task automatic prio(input logic [1:0] a, input logic [1:0] b);
    sync_sop();
    send(1'b0, a, 8'd20, 8'h11, 16'h0, 1'b1);
    send(1'b0, b, 8'd20, 8'h22, 16'h0, 1'b1);
    get_pkt();
    chk("winner", {pkt[1], pkt[5]}, {8'h41, 8'(b) + 8'h01});
    get_pkt();
    chk("loser", {pkt[1], pkt[5]}, {8'h41, 8'(a) + 8'h01});
    get_pkt();
    chk("idle", pkt[1], 8'h1f);
  endtask : prio
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(REG_CTRL, d);
    chk("ctrl", d, 32'(CTRL_RST));
    rd(REG_IVL, d);
    chk("ivl", d, 32'(IVL_RST));
    rd(REG_PHB, d);
    chk("phb", d, 32'(PHB_RST));
    wr(REG_CAP, 32'h0);
    rd(REG_CAP, d);
    chk("cap", d, CAP_VAL);
    wr(REG_IVL, 32'h0000ffff);
    get_pkt();
    chk("null hdr", {pkt[0], pkt[1], pkt[2], pkt[4]}, {TS_SYNC, 8'h1f, 8'hff, STUFF});
    for (int k = 5; k < PKT_LEN; k++) chk("null body", pkt[k], STUFF);
    // Exactly 256 master ticks in 1250 clocks
    rd(REG_TS, t0);
    repeat (1248) @(posedge clk);
    rd(REG_TS, d);
    chk("ts rate", d - t0, 32'd256);
    for (int i = 0; i < 6; i++) begin
      f = 2'($random(seed));
      l = i == 0 ? 8'd1 : i == 1 ? 8'd183 : 8'($unsigned($random(seed)) % 183 + 1);
      s = 8'($random(seed));
      send(1'b0, f, l, s, 16'h0, 1'b1);
      chk_frame(f, l, s);
    end
    // Core maps ride the expedited flow
    wr(REG_PHB, 32'(PHB_EF) << 12);
    prio(2'd0, 2'd2);
    wr(REG_PHB, 32'(PHB_EF));
    wr(REG_CTRL, 32'h5);
    prio(2'd0, 2'd3);
    // OFDM alone still runs packet mode
    wr(REG_CTRL, 32'h2);
    sa_lo = $random(seed);
    sa_hi = $random(seed);
    wr(REG_SA_LO, sa_lo);
    wr(REG_SA_HI, sa_hi);
    wr(REG_IVL, 32'h1);
    find(8'h41, FC_TIMING, 1'b1);
    sv = {8'h00, FC_TIMING, 8'h00, MAC_LEN, 16'h0000, SYNC_DA, sa_hi[15:0], sa_lo, MSG_LEN,
      LLC_SAP, LLC_SAP, LLC_UI, MSG_VER, MSG_TYPE, 8'h00};
    for (int k = 4; k < 31; k++)
      chk("sync", pkt[k], sv[8*(30-k) +: 8]);
    for (int k = 35; k < PKT_LEN; k++) chk("sync stuff", pkt[k], STUFF);
    // Second copy of seq 5 is stale and must vanish
    wr(REG_CTRL, 32'h0);
    send(1'b1, 2'd2, 8'd188, 8'h5a, 16'h0005, 1'b1);
    // Catch the first packet before the seq 6 one can drain behind it
    find(8'h02, 8'h00, 1'b0);
    for (int k = 0; k < PKT_LEN; k++)
      chk("pass", pkt[k], dpd_byte(1'b1, 2'd0, 8'h5a, 8'(k)));
    send(1'b1, 2'd1, 8'd188, 8'h66, 16'h0005, 1'b0);
    send(1'b1, 2'd3, 8'd188, 8'h77, 16'h0006, 1'b1);
    rd(REG_STAT, d);
    chk("stat", {d[31:16], d[3:0]}, {16'h0001, 4'h1});
    find(8'h02, 8'h00, 1'b0);
    chk("pass order", pkt[4], 8'h77);
    // Embedded timing message: fresh stamp, every other byte untouched
    send(1'b1, 2'd0, 8'd188, 8'h00, 16'h0007, 1'b1);
    find(8'h42, 8'hc0, 1'b1);
    t0 = {pkt[31], pkt[32], pkt[33], pkt[34]};
    rd(REG_TS, d);
    for (int k = 0; k < PKT_LEN; k++)
      if (k < 31 || k > 34) chk("fix pass", pkt[k], dpd_byte(1'b1, 2'd0, 8'h00, 8'(k)));
    // Stamp taken at byte 5, read back about 1822 clocks later
    chk("fix ts", 32'(d - t0 - 32'd371 < 32'd5), 32'h1);
    stop_test();
  end
  initial begin
    #1800000;
    num_errors++;
    stop_test();
  end
endmodule : testbench
